// ### hdl/ext_pin_irq_consts.vh
`ifndef EXT_PIN_IRQ_CONSTS_VH
`define EXT_PIN_IRQ_CONSTS_VH

// register byte addresses
`define ADDR_SENSE_CTRL 8'h00
`define ADDR_EXT_MASK 8'h04
`define ADDR_EXT_FLAGS 8'h08
`define ADDR_GROUP_ENABLE 8'h0c
`define ADDR_GROUP_FLAGS 8'h10
`define ADDR_GROUP0_MASK 8'h14
`define ADDR_GROUP1_MASK 8'h18
`define ADDR_GROUP2_MASK 8'h1c
`define ADDR_GROUP3_MASK 8'h20

// reset values
`define RESET_BYTE 8'h00
`define RESET_NIBBLE 4'h0
`define RESET_PAIR 2'h0
`define RESET_WORD 32'h0000_0000
`define RESET_WATCH 28'h000_0000

// field positions
`define LINE_A_SEL_HI 1
`define LINE_A_SEL_LO 0
`define LINE_B_SEL_HI 3
`define LINE_B_SEL_LO 2
`define LINE_A_BIT 0
`define LINE_B_BIT 1

// trigger select encodings
`define TRIG_LOW_LEVEL 2'h0
`define TRIG_ANY_CHANGE 2'h1
`define TRIG_FALLING 2'h2
`define TRIG_RISING 2'h3

// change input groups
`define G0_HI 7
`define G0_LO 0
`define G1_HI 15
`define G1_LO 8
`define G2_HI 23
`define G2_LO 16
`define G3_HI 27
`define G3_LO 24

// request vector order
`define VEC_LINE_A 0
`define VEC_LINE_B 1
`define VEC_GROUP0 2
`define VEC_GROUP3 5

`endif

// ### hdl/ext_and_pin_change_irq.v
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ext_pin_irq_consts.vh"

module ext_and_pin_change_irq (
  // clock and reset
  input wire clock,
  input wire resetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // pins
  input wire extLineA,
  input wire extLineB,
  input wire [27:0] changeWatchInputs,
  // processor side
  input wire globalIrqEnable,
  input wire [5:0] handlerEntry,
  output wire [5:0] irqRequest,
  output wire wakeRequest
);

  reg [7:0] senseCtrl;
  reg [1:0] extMask;
  reg [1:0] extFlags;
  reg [3:0] groupEnable;
  reg [3:0] groupFlags;
  reg [27:0] watchMask;
  reg [29:0] syncFirst;
  reg [29:0] syncSecond;
  reg [29:0] syncPrev;
  reg [31:0] next_prdata;
  reg [1:0] next_extFlags;
  reg [1:0] lineHit;
  reg [1:0] lineLevel;
  reg addrOk;
  integer i;

  wire setupPhase = psel & ~penable;
  wire writeDone = psel & penable & pwrite & addrOk;
  wire [29:0] cur = syncSecond;
  wire [27:0] watchChange = (cur[27:0] ^ syncPrev[27:0]) & watchMask;
  wire [3:0] groupChange;
  wire [3:0] next_groupFlags;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addrOk;

  // two flops on every pin before any logic
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      syncFirst <= 30'h0000_0000;
      syncSecond <= 30'h0000_0000;
      syncPrev <= 30'h0000_0000;
    end else begin
      syncFirst <= {extLineB, extLineA, changeWatchInputs};
      syncSecond <= syncFirst;
      syncPrev <= syncSecond;
    end
  end

  always @* begin
    case (paddr)
      `ADDR_SENSE_CTRL, `ADDR_EXT_MASK, `ADDR_EXT_FLAGS, `ADDR_GROUP_ENABLE,
      `ADDR_GROUP_FLAGS, `ADDR_GROUP0_MASK, `ADDR_GROUP1_MASK, `ADDR_GROUP2_MASK,
      `ADDR_GROUP3_MASK: addrOk = 1'b1;
      default: addrOk = 1'b0;
    endcase
  end

  // read mux; upper bits stay zero
  always @* begin
    next_prdata = `RESET_WORD;
    case (paddr)
      `ADDR_SENSE_CTRL: next_prdata[3:0] = senseCtrl[3:0];
      `ADDR_EXT_MASK: next_prdata[1:0] = extMask;
      `ADDR_EXT_FLAGS: next_prdata[1:0] = extFlags;
      `ADDR_GROUP_ENABLE: next_prdata[3:0] = groupEnable;
      `ADDR_GROUP_FLAGS: next_prdata[3:0] = groupFlags;
      `ADDR_GROUP0_MASK: next_prdata[7:0] = watchMask[`G0_HI:`G0_LO];
      `ADDR_GROUP1_MASK: next_prdata[7:0] = watchMask[`G1_HI:`G1_LO];
      `ADDR_GROUP2_MASK: next_prdata[7:0] = watchMask[`G2_HI:`G2_LO];
      `ADDR_GROUP3_MASK: next_prdata[3:0] = watchMask[`G3_HI:`G3_LO];
      default: next_prdata = `RESET_WORD;
    endcase
  end

  // trigger decode per external line
  always @* begin
    next_extFlags = extFlags;
    lineHit = 2'h0;
    lineLevel = 2'h0;
    for (i = 0; i < 2; i = i + 1) begin
      case (i == `LINE_B_BIT ? senseCtrl[`LINE_B_SEL_HI:`LINE_B_SEL_LO]
                             : senseCtrl[`LINE_A_SEL_HI:`LINE_A_SEL_LO])
        `TRIG_LOW_LEVEL: begin
          lineHit[i] = 1'b0;
          lineLevel[i] = ~cur[28 + i];
        end
        `TRIG_ANY_CHANGE: lineHit[i] = cur[28 + i] ^ syncPrev[28 + i];
        `TRIG_FALLING: lineHit[i] = syncPrev[28 + i] & ~cur[28 + i];
        `TRIG_RISING: lineHit[i] = ~syncPrev[28 + i] & cur[28 + i];
        default: lineHit[i] = 1'b0;
      endcase
      if (lineLevel[i] || (i == `LINE_B_BIT ?
          senseCtrl[`LINE_B_SEL_HI:`LINE_B_SEL_LO] == `TRIG_LOW_LEVEL :
          senseCtrl[`LINE_A_SEL_HI:`LINE_A_SEL_LO] == `TRIG_LOW_LEVEL))
        next_extFlags[i] = 1'b0;
      else if (lineHit[i])
        next_extFlags[i] = 1'b1;
      else if (handlerEntry[`VEC_LINE_A + i] ||
               (writeDone && paddr == `ADDR_EXT_FLAGS && pwdata[i]))
        next_extFlags[i] = 1'b0;
    end
  end

  assign groupChange[0] = |watchChange[`G0_HI:`G0_LO];
  assign groupChange[1] = |watchChange[`G1_HI:`G1_LO];
  assign groupChange[2] = |watchChange[`G2_HI:`G2_LO];
  assign groupChange[3] = |watchChange[`G3_HI:`G3_LO];

  // set wins over clear; writing zero keeps the flag
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : groupFlag
      assign next_groupFlags[g] = groupChange[g] | (groupFlags[g] &
        ~(handlerEntry[`VEC_GROUP0 + g] |
          (writeDone & (paddr == `ADDR_GROUP_FLAGS) & pwdata[g])));
    end
  endgenerate

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      senseCtrl <= `RESET_BYTE;
      extMask <= `RESET_PAIR;
      extFlags <= `RESET_PAIR;
      groupEnable <= `RESET_NIBBLE;
      groupFlags <= `RESET_NIBBLE;
      watchMask <= `RESET_WATCH;
      prdata <= `RESET_WORD;
    end else begin
      extFlags <= next_extFlags;
      groupFlags <= next_groupFlags;
      if (setupPhase)
        prdata <= next_prdata;
      if (writeDone) begin
        case (paddr)
          `ADDR_SENSE_CTRL: senseCtrl <= {4'h0, pwdata[3:0]};
          `ADDR_EXT_MASK: extMask <= pwdata[1:0];
          `ADDR_GROUP_ENABLE: groupEnable <= pwdata[3:0];
          `ADDR_GROUP0_MASK: watchMask[`G0_HI:`G0_LO] <= pwdata[7:0];
          `ADDR_GROUP1_MASK: watchMask[`G1_HI:`G1_LO] <= pwdata[7:0];
          `ADDR_GROUP2_MASK: watchMask[`G2_HI:`G2_LO] <= pwdata[7:0];
          `ADDR_GROUP3_MASK: watchMask[`G3_HI:`G3_LO] <= pwdata[3:0];
          default: senseCtrl <= senseCtrl;
        endcase
      end
    end
  end

  // one request line per source
  assign irqRequest[`VEC_LINE_A] = globalIrqEnable & extMask[`LINE_A_BIT] &
    (extFlags[`LINE_A_BIT] | lineLevel[`LINE_A_BIT]);
  assign irqRequest[`VEC_LINE_B] = globalIrqEnable & extMask[`LINE_B_BIT] &
    (extFlags[`LINE_B_BIT] | lineLevel[`LINE_B_BIT]);
  assign irqRequest[`VEC_GROUP3:`VEC_GROUP0] =
    {4{globalIrqEnable}} & groupEnable & groupFlags;

  // wake does not need the global enable
  assign wakeRequest = |(groupEnable & groupFlags) |
    |(extMask & (extFlags | lineLevel));

endmodule

// ### verification/cpu_dispatch_model.sv
`timescale 1ns/1ps
module cpu_dispatch_model (
  // clock and reset
  input wire clock,
  input wire resetn,
  // dispatch side
  input wire autoAck,
  input wire [5:0] irqRequest,
  output reg [5:0] handlerEntry
);
  // enters the lowest pending vector, one pulse then a gap
  always @(posedge clock or negedge resetn) begin
    if (!resetn) handlerEntry <= 6'h00;
    else if (autoAck && handlerEntry == 6'h00) handlerEntry <= irqRequest & (~irqRequest + 6'h01);
    else handlerEntry <= 6'h00;
  end
endmodule

// ### verification/irq_port_monitor.sv
`timescale 1ns/1ps
module irq_port_monitor (
  // clock, reset and apb
  input wire clock,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // interrupt side
  input wire [27:0] changeWatchInputs,
  input wire globalIrqEnable,
  input wire [5:0] handlerEntry,
  input wire [5:0] irqRequest,
  input wire wakeRequest
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  reg [27:0] p1, p2, p3;
  wire rdAcc = psel && penable && !pwrite;
  wire flagWr = psel && penable && pwrite && paddr == 8'h10;
  // no change old enough to set a flag at the next edge
  wire quiet = p1 == p2 && p2 == p3;
  always @(posedge clock) begin
    p1 <= changeWatchInputs;
    p2 <= p1;
    p3 <= p2;
  end
  gie_gate_a: assert property (!globalIrqEnable |-> irqRequest == 6'h00)
    else $error("request without global enable");
  wake_any_a: assert property (irqRequest != 6'h00 |-> wakeRequest)
    else $error("request without wake");
  wake_gie_a: assert property (wakeRequest && globalIrqEnable |-> irqRequest != 6'h00)
    else $error("wake without request");
  ext_upper_a: assert property (rdAcc && paddr inside {8'h04, 8'h08} |-> prdata[31:2] == 0)
    else $error("upper bits set");
  byte_upper_a: assert property (rdAcc && paddr inside {8'h00, 8'h0c, 8'h10, 8'h20}
    |-> prdata[31:4] == 0)
    else $error("upper bits set");
  handler_clr_a: assert property (handlerEntry[2] && quiet |=> !irqRequest[2])
    else $error("handler entry did not clear");
  write_clr_a: assert property (flagWr && pwdata[3] && quiet |=> !irqRequest[5])
    else $error("write one did not clear");
  zero_keep_a: assert property (flagWr && pwdata[3:0] == 4'h0 && irqRequest[5] &&
    handlerEntry == 6'h00 |=> irqRequest[5] || !globalIrqEnable) else $error("flag lost");
  cover property (handlerEntry[2]);
  cover property (flagWr && pwdata[3]);
  cover property (wakeRequest && !globalIrqEnable);
endmodule
bind ext_and_pin_change_irq irq_port_monitor u_mon (.clock(clock), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .changeWatchInputs(changeWatchInputs), .globalIrqEnable(globalIrqEnable),
  .handlerEntry(handlerEntry), .irqRequest(irqRequest), .wakeRequest(wakeRequest));

// ### verification/ext_and_pin_change_irq_tb.sv
`timescale 1ns/1ps
module ext_and_pin_change_irq_tb;
  reg clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, gie = 0, autoAck = 0;
  reg extA = 1, extB = 1;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0, rdat;
  reg slv = 0;
  reg [27:0] cw = 0;
  wire [31:0] prdata;
  wire pready, pslverr, wake;
  wire [5:0] irq, hEntry;
  integer err_count = 0, num_checks = 0, l, m, g;
  always #10 clock = ~clock;
  ext_and_pin_change_irq u_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extLineA(extA), .extLineB(extB), .changeWatchInputs(cw),
    .globalIrqEnable(gie), .handlerEntry(hEntry), .irqRequest(irq), .wakeRequest(wake));
  cpu_dispatch_model u_cpu (.clock(clock), .resetn(resetn), .autoAck(autoAck),
    .irqRequest(irq), .handlerEntry(hEntry));
  task stop_test;
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    integer n;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    n = 0;
    @(posedge clock);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clock);
      n = n + 1;
    end
    if (n == 16) begin
      err_count = err_count + 1;
      stop_test;
    end
    rdat = prdata;
    slv = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] e, input string nm);
    xfer(0, a, 0);
    chk(rdat, e, nm);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1;
    for (g = 0; g < 9; g = g + 1) rd(8'(4 * g), 0, "reset value");
    rd(8'h24, 0, "unmapped");
    chk(slv, 1, "unmapped error");
    for (g = 0; g < 4; g = g + 1) begin
      xfer(1, 8'(32'h2000_0c04 >> (8 * g)), 32'hffff_ffff);
      rd(8'(32'h2000_0c04 >> (8 * g)), 32'(8'(32'h0f0f_0f03 >> (8 * g))), "used bits");
    end
    gie <= 1;
    for (l = 0; l < 2; l = l + 1) for (m = 1; m < 4; m = m + 1) begin
      xfer(1, 8'h04, 1 << l);
      xfer(1, 8'h00, m << (2 * l));
      {extB, extA} <= 2'b00;
      repeat (4) @(posedge clock);
      rd(8'h08, (m != 3 ? 1 : 0) << l, "flag on fall");
      chk(irq, (m != 3 ? 1 : 0) << l, "request on fall");
      xfer(1, 8'h08, 0);
      rd(8'h08, (m != 3 ? 1 : 0) << l, "flag kept");
      xfer(1, 8'h08, 3);
      {extB, extA} <= 2'b11;
      repeat (4) @(posedge clock);
      rd(8'h08, (m != 2 ? 1 : 0) << l, "flag on rise");
      xfer(1, 8'h08, 3);
      rd(8'h08, 0, "flag cleared");
    end
    xfer(1, 8'h04, 1);
    xfer(1, 8'h00, 0);
    extA <= 0;
    repeat (3) @(posedge clock);
    chk(irq, 1, "level request");
    rd(8'h08, 0, "level flag");
    gie <= 0;
    @(posedge clock);
    chk({irq, wake}, 1, "gated wake");
    gie <= 1; extA <= 1;
    xfer(1, 8'h04, 0);
    for (g = 0; g < 4; g = g + 1) begin
      xfer(1, 8'(8'h14 + 4 * g), 1);
      xfer(1, 8'h0c, 1 << g);
      cw[8 * g + 1] <= 1;
      repeat (4) @(posedge clock);
      rd(8'h10, 0, "masked input");
      cw[8 * g] <= 1;
      repeat (4) @(posedge clock);
      rd(8'h10, 1 << g, "group flag");
      chk(irq, 4 << g, "group request");
      xfer(1, 8'h10, 0);
      xfer(1, 8'h10, 32'h0f);
      @(negedge clock);
      chk(irq, 0, "write one clear");
      cw[8 * g] <= 0; autoAck <= 1;
      repeat (7) @(posedge clock);
      chk(irq, 0, "handler clear");
      autoAck <= 0;
      xfer(1, 8'(8'h14 + 4 * g), 0);
    end
    stop_test;
  end
  initial begin
    #200000;
    err_count = err_count + 1;
    stop_test;
  end
endmodule
